// file: adcsq_sequencer.sv
// two-channel conversion request sequencer with its register file
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/100ps

module adcsq_sequencer
  import adcsq_pkg::*;
(
  input  wire logic              CLOCK,           // system clock, 100 MHz
  input  wire logic              SRST,            // synchronous reset, active high
  input  wire logic [ADDR_W-1:0] ADDR,            // register address
  input  wire logic [DATA_W-1:0] WDATA,           // register write data
  input  wire logic              WR,              // write strobe
  input  wire logic              RD,              // read strobe
  output logic      [DATA_W-1:0] RDATA,           // read data, cycle after RD
  input  wire logic [RES_W-1:0]  CORE_RESULT,     // word from the analog core
  output logic      [SEL_W-1:0]  MUX_SELECT,      // analog multiplexer select
  output logic                   SAMPLE_HOLD,     // sample phase active
  output logic                   CONVERT_ACTIVE,  // conversion phase active
  output logic                   RESOLUTION_NINE  // core runs at 9 bits
);
  logic enable_r;
  logic enable_nxt;
  logic configured_r;
  logic configured_nxt;
  logic res_nine_r;
  logic res_nine_nxt;
  logic run_ok;

  logic wr_ctl;
  logic wr_otp;
  logic [1:0] wr_cfg;

  adcsq_state_type state_r;
  adcsq_state_type state_nxt;
  logic cur_r;
  logic cur_nxt;
  logic pick;
  logic [1:0] finish;
  logic tmr_load;
  logic [TIMER_W-1:0] tmr_val;
  logic tmr_abort;
  logic tmr_expired;

  logic [SEL_W-1:0]   sel_q  [2];
  logic [SAMP_W-1:0]  samp_q [2];
  logic [RES_W-1:0]   res_q  [2];
  logic [TIMER_W-1:0] samp_cyc [2];
  logic [1:0] repeat_q;
  logic [1:0] pend_q;
  logic [1:0] done_q;

  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [SEL_W-1:0]  mux_r;
  logic [SEL_W-1:0]  mux_nxt;
  logic sample_r;
  logic convert_r;

  // sample length in cycles for a code and resolution
  function automatic logic [TIMER_W-1:0] sample_cycles(input logic [SAMP_W-1:0] code, input logic nine);
    logic [TIMER_W-1:0] base;
    base = nine ? TIMER_W'(SAMP9_MIN_CYC) : TIMER_W'(SAMP8_MIN_CYC);
    return base << code;
  endfunction

  // write address decode
  always_comb
  begin
    wr_ctl = 1'b0;
    wr_otp = 1'b0;
    wr_cfg = 2'b00;
    if (WR)
    begin
      if (ADDR == OFS_CONTROL)
        wr_ctl = 1'b1;
      else if (ADDR == OFS_OTP)
        wr_otp = 1'b1;
      else if (ADDR == OFS_CFG_ONE)
        wr_cfg[0] = 1'b1;
      else if (ADDR == OFS_CFG_TWO)
        wr_cfg[1] = 1'b1;
    end
  end

  // global control: enable and one-time resolution
  always_comb
  begin
    enable_nxt     = wr_ctl ? WDATA[CTL_ENABLE_BIT] : enable_r;
    configured_nxt = configured_r | wr_otp;
    res_nine_nxt   = res_nine_r;
    if (wr_otp && !configured_r)
      res_nine_nxt = WDATA[OTP_RES_BIT];
  end

  assign run_ok = enable_r & configured_r;

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      enable_r     <= 1'b0;
      configured_r <= 1'b0;
      res_nine_r   <= 1'b0;
    end
    else
    begin
      enable_r     <= enable_nxt;
      configured_r <= configured_nxt;
      res_nine_r   <= res_nine_nxt;
    end
  end

  // per-channel request, flag and result state
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_chan
      logic [SEL_W-1:0]  sel_r;
      logic [SEL_W-1:0]  sel_nxt;
      logic [SAMP_W-1:0] samp_r;
      logic [SAMP_W-1:0] samp_nxt;
      logic [RES_W-1:0]  res_r;
      logic [RES_W-1:0]  res_nxt;
      logic repeat_r;
      logic repeat_nxt;
      logic pend_r;
      logic pend_nxt;
      logic done_r;
      logic done_nxt;

      always_comb
      begin
        sel_nxt    = sel_r;
        samp_nxt   = samp_r;
        repeat_nxt = repeat_r;
        pend_nxt   = pend_r;
        done_nxt   = done_r;
        res_nxt    = res_r;
        if (wr_cfg[gi])
        begin
          // host keeps these fixed while repeating
          sel_nxt    = WDATA[CFG_SEL_LSB +: SEL_W];
          samp_nxt   = WDATA[CFG_SAMP_LSB +: SAMP_W];
          repeat_nxt = WDATA[CFG_REPEAT_BIT];
          if (!pend_r && (WDATA[CFG_TRIG_BIT] || WDATA[CFG_REPEAT_BIT]))
          begin
            pend_nxt = 1'b1;
            done_nxt = 1'b0;
          end
        end
        if (finish[gi])
        begin
          // nine-bit word, low bit zero at 8 bits
          res_nxt  = res_nine_r ? CORE_RESULT : {CORE_RESULT[RES_W-1:1], 1'b0};
          done_nxt = 1'b1;
          pend_nxt = repeat_r;
        end
      end

      always_ff @(posedge CLOCK)
      begin
        if (SRST)
        begin
          sel_r    <= SEL_RESET;
          samp_r   <= SAMP_RESET;
          res_r    <= RES_RESET;
          repeat_r <= 1'b0;
          pend_r   <= 1'b0;
          done_r   <= 1'b0;
        end
        else
        begin
          sel_r    <= sel_nxt;
          samp_r   <= samp_nxt;
          res_r    <= res_nxt;
          repeat_r <= repeat_nxt;
          pend_r   <= pend_nxt;
          done_r   <= done_nxt;
        end
      end

      assign sel_q[gi]    = sel_r;
      assign samp_q[gi]   = samp_r;
      assign res_q[gi]    = res_r;
      assign repeat_q[gi] = repeat_r;
      assign pend_q[gi]   = pend_r;
      assign done_q[gi]   = done_r;
      assign samp_cyc[gi] = sample_cycles(samp_r, res_nine_r);
    end
  endgenerate

  // channel choice when both wait
  always_comb
  begin
    if (pend_q == 2'b11)
    begin
      pick = (repeat_q != 2'b00) ? ~cur_r : 1'b0;
    end
    else
      pick = pend_q[1];
  end

  // sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    cur_nxt   = cur_r;
    finish    = 2'b00;
    tmr_load  = 1'b0;
    tmr_val   = '0;
    tmr_abort = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (run_ok && (pend_q != 2'b00))
        begin
          cur_nxt   = pick;
          tmr_load  = 1'b1;
          tmr_val   = samp_cyc[pick];
          state_nxt = ST_SAMPLE;
        end
      end
      ST_SAMPLE:
      begin
        if (!run_ok)
        begin
          tmr_abort = 1'b1;
          state_nxt = ST_IDLE;
        end
        else if (tmr_expired)
        begin
          tmr_load  = 1'b1;
          tmr_val   = res_nine_r ? CONV9_CYC : CONV8_CYC;
          state_nxt = ST_CONVERT;
        end
      end
      ST_CONVERT:
      begin
        if (!run_ok)
        begin
          tmr_abort = 1'b1;
          state_nxt = ST_IDLE;
        end
        else if (tmr_expired)
        begin
          finish[cur_r] = 1'b1;
          state_nxt     = ST_IDLE;
        end
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  adcsq_timer u_timer (
    .clk      (CLOCK),
    .srst     (SRST),
    .load     (tmr_load),
    .load_val (tmr_val),
    .abort    (tmr_abort),
    .expired  (tmr_expired)
  );

  // read data and pin drives
  always_comb
  begin
    rdata_nxt = '0;
    if (RD)
    begin
      if (ADDR == OFS_CONTROL)
      begin
        rdata_nxt[CTL_ENABLE_BIT]     = enable_r;
        rdata_nxt[CTL_CONFIGURED_BIT] = configured_r;
        rdata_nxt[CTL_RES_BIT]        = res_nine_r;
        rdata_nxt[CTL_BUSY_BIT]       = (state_r != ST_IDLE);
      end
      else if (ADDR == OFS_OTP)
        rdata_nxt[OTP_RES_BIT] = res_nine_r;
      else if (ADDR == OFS_CFG_ONE || ADDR == OFS_CFG_TWO)
      begin
        rdata_nxt[CFG_SEL_LSB +: SEL_W]   = sel_q[ADDR == OFS_CFG_TWO];
        rdata_nxt[CFG_SAMP_LSB +: SAMP_W] = samp_q[ADDR == OFS_CFG_TWO];
        rdata_nxt[CFG_REPEAT_BIT]         = repeat_q[ADDR == OFS_CFG_TWO];
      end
      else if (ADDR == OFS_RES_ONE || ADDR == OFS_RES_TWO)
      begin
        rdata_nxt[RES_W-1:0]   = res_q[ADDR == OFS_RES_TWO];
        rdata_nxt[RES_DONE_BIT] = done_q[ADDR == OFS_RES_TWO];
      end
    end
    mux_nxt = (state_nxt != ST_IDLE) ? sel_q[cur_nxt] : mux_r;
  end

  // register state and outputs
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      state_r   <= ST_IDLE;
      cur_r     <= 1'b1;
      rdata_r   <= '0;
      mux_r     <= SEL_RESET;
      sample_r  <= 1'b0;
      convert_r <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      cur_r     <= cur_nxt;
      rdata_r   <= rdata_nxt;
      mux_r     <= mux_nxt;
      sample_r  <= (state_nxt == ST_SAMPLE);
      convert_r <= (state_nxt == ST_CONVERT);
    end
  end

  assign RDATA           = rdata_r;
  assign MUX_SELECT      = mux_r;
  assign SAMPLE_HOLD     = sample_r;
  assign CONVERT_ACTIVE  = convert_r;
  assign RESOLUTION_NINE = res_nine_r;
endmodule

// file: adcsq_timer.sv
// package of shared constants and the cycle timer used by the conversion sequencer
package adcsq_pkg;
  // register port shape
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CFG_ONE = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_CFG_TWO = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_RES_ONE = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_RES_TWO = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_OTP     = 5'h14;

  // conv_control_reg fields
  localparam int CTL_ENABLE_BIT     = 0;
  localparam int CTL_CONFIGURED_BIT = 1;
  localparam int CTL_RES_BIT        = 2;
  localparam int CTL_BUSY_BIT       = 3;
  // one-time configuration register field
  localparam int OTP_RES_BIT = 0;

  // channel_config_reg fields
  localparam int CFG_SEL_LSB    = 0;
  localparam int SEL_W          = 5;
  localparam int CFG_SAMP_LSB   = 5;
  localparam int SAMP_W         = 3;
  localparam int CFG_TRIG_BIT   = 8;
  localparam int CFG_REPEAT_BIT = 9;

  // channel_result_reg fields
  localparam int RES_W        = 9;
  localparam int RES_DONE_BIT = 15;

  // reset values
  localparam logic [SEL_W-1:0]  SEL_RESET  = 5'h00;
  localparam logic [SAMP_W-1:0] SAMP_RESET = 3'h0;
  localparam logic [RES_W-1:0]  RES_RESET  = 9'h000;

  // timing, clock period in ns
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV8_NS      = 5500;
  localparam int CONV9_NS      = 10000;
  localparam int SAMP8_MIN_CYC = 16;
  localparam int SAMP9_MIN_CYC = 32;
  localparam int TIMER_W       = 13;
  // conversion phase after sampling; a longest time rounds down
  localparam logic [TIMER_W-1:0] CONV8_CYC = TIMER_W'(CONV8_NS / CLK_PERIOD_NS - SAMP8_MIN_CYC);
  localparam logic [TIMER_W-1:0] CONV9_CYC = TIMER_W'(CONV9_NS / CLK_PERIOD_NS - SAMP9_MIN_CYC);
  localparam logic [TIMER_W-1:0] TIMER_LAST = 13'h0001;

  // sequencer states, gray along idle-sample-convert
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b11
  } adcsq_state_type;
endpackage

`timescale 1ns/100ps

module adcsq_timer
  import adcsq_pkg::*;
(
  input  wire logic               clk,      // system clock
  input  wire logic               srst,     // synchronous reset
  input  wire logic               load,     // start a new interval
  input  wire logic [TIMER_W-1:0] load_val, // interval length in cycles
  input  wire logic               abort,    // stop without expiring
  output logic                    expired   // one-cycle pulse at interval end
);
  logic [TIMER_W-1:0] cnt_r;
  logic [TIMER_W-1:0] cnt_nxt;
  logic               expired_r;
  logic               expired_nxt;

  // count down, abort wins over load
  always_comb
  begin
    cnt_nxt     = cnt_r;
    expired_nxt = 1'b0;
    if (abort)
      cnt_nxt = '0;
    else if (load)
      cnt_nxt = load_val;
    else if (cnt_r != '0)
    begin
      cnt_nxt     = cnt_r - TIMER_LAST;
      expired_nxt = (cnt_r == TIMER_LAST);
    end
  end

  // register the counter
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_r     <= '0;
      expired_r <= 1'b0;
    end
    else
    begin
      cnt_r     <= cnt_nxt;
      expired_r <= expired_nxt;
    end
  end

  assign expired = expired_r;
endmodule

// file: adcsq_asserts.sv
// assertion checker for the conversion sequencer ports
`timescale 1ns/100ps
module adcsq_asserts
  import adcsq_pkg::*;
(
  input logic              CLOCK,          // clock
  input logic              SRST,           // reset
  input logic [ADDR_W-1:0] ADDR,           // address
  input logic [DATA_W-1:0] WDATA,          // write data
  input logic              WR,             // write strobe
  input logic              RD,             // read strobe
  input logic [DATA_W-1:0] RDATA,          // read data
  input logic [RES_W-1:0]  CORE_RESULT,    // core word
  input logic [SEL_W-1:0]  MUX_SELECT,     // mux select
  input logic              SAMPLE_HOLD,    // sample phase
  input logic              CONVERT_ACTIVE, // convert phase
  input logic              RESOLUTION_NINE // 9-bit mode
);
  logic               cfg_r;
  logic               cfg_nxt;
  logic               en_r;
  logic               en_nxt;
  logic               otp_one;
  logic [TIMER_W-1:0] sc_r;
  logic [TIMER_W-1:0] sc_nxt;
  logic [TIMER_W-1:0] cc_r;
  logic [TIMER_W-1:0] cc_nxt;
  // track configuration, enable and phase lengths
  always_comb
  begin
    otp_one = WR && ADDR == OFS_OTP && WDATA[OTP_RES_BIT];
    cfg_nxt = !SRST && (cfg_r || (WR && ADDR == OFS_OTP));
    en_nxt  = !SRST && ((WR && ADDR == OFS_CONTROL) ? WDATA[CTL_ENABLE_BIT] : en_r);
    sc_nxt  = (SRST || !SAMPLE_HOLD) ? 13'h0000 : sc_r + 13'h0001;
    cc_nxt  = (SRST || !CONVERT_ACTIVE) ? 13'h0000 : cc_r + 13'h0001;
  end
  // register helper state
  always_ff @(posedge CLOCK)
  begin
    cfg_r <= cfg_nxt;
    en_r  <= en_nxt;
    sc_r  <= sc_nxt;
    cc_r  <= cc_nxt;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  AST_ONE_PHASE: assert property (!(SAMPLE_HOLD && CONVERT_ACTIVE))
    else $error("sample and convert together");
  AST_MUX_HOLD: assert property ($past(SAMPLE_HOLD) && (SAMPLE_HOLD || CONVERT_ACTIVE) |-> $stable(MUX_SELECT))
    else $error("mux select moved mid conversion");
  AST_OTP_LOCK: assert property (!$fell(RESOLUTION_NINE))
    else $error("resolution dropped");
  AST_RES_SRC: assert property ($rose(RESOLUTION_NINE) |-> $past(otp_one) && !$past(cfg_r))
    else $error("resolution rose without first config write");
  AST_START_CFG: assert property ($rose(SAMPLE_HOLD) |-> $past(cfg_r))
    else $error("start before configuration");
  AST_START_EN: assert property ($rose(SAMPLE_HOLD) |-> $past(en_r))
    else $error("start while disabled");
  AST_SAMP_TO_CONV: assert property ($fell(SAMPLE_HOLD) && en_r |-> CONVERT_ACTIVE)
    else $error("sample not followed by conversion");
  AST_CONV_LEN: assert property (
    $fell(CONVERT_ACTIVE) && en_r |-> cc_r == (RESOLUTION_NINE ? CONV9_CYC : CONV8_CYC) + 13'h0001)
    else $error("conversion length wrong");
  AST_SAMP_LEN: assert property (
    $fell(SAMPLE_HOLD) && en_r |-> sc_r >= (RESOLUTION_NINE ? 13'h0021 : 13'h0011)
    && sc_r <= (RESOLUTION_NINE ? 13'h1001 : 13'h0801))
    else $error("sample length out of range");
endmodule
bind adcsq_sequencer adcsq_asserts u_asserts (
  .CLOCK(CLOCK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .CORE_RESULT(CORE_RESULT), .MUX_SELECT(MUX_SELECT), .SAMPLE_HOLD(SAMPLE_HOLD),
  .CONVERT_ACTIVE(CONVERT_ACTIVE), .RESOLUTION_NINE(RESOLUTION_NINE));

// file: adcsq_core_model.sv
// analog core stand-in giving a select-dependent word during conversion
`timescale 1ns/100ps
module adcsq_core_model
  import adcsq_pkg::*;
(
  input  logic             clk,        // clock
  input  logic [SEL_W-1:0] mux_select, // selected input
  input  logic             converting, // conversion phase
  output logic [RES_W-1:0] core_result // word to sequencer
);
  logic [RES_W-1:0] churn_r = 9'h000;
  // moving pattern outside conversions so a stale capture shows
  always_ff @(posedge clk)
    churn_r <= churn_r + 9'h0a7;
  assign core_result = converting ? {mux_select, 4'h5} : churn_r;
endmodule

// file: adcsq_sequencer_test.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module adcsq_sequencer_test
  import adcsq_pkg::*;
;
  logic              clock = 1'b0;
  logic              srst  = 1'b1;
  logic              wr_s  = 1'b0;
  logic              rd_s  = 1'b0;
  logic [ADDR_W-1:0] addr  = 5'h00;
  logic [DATA_W-1:0] wdata = 16'h0000;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rd_v;
  logic [RES_W-1:0]  core_w;
  logic [SEL_W-1:0]  mux;
  logic              samp;
  logic              conv_a;
  logic              nine_o;
  logic [31:0]       rng = 32'h07b2;
  int                n_mismatch = 0;
  int                tests_run = 0;
  int                cycles = 0;
  int                nine = 0;
  int                sel_a[2];
  int                code_a[2];
  int                exp_q[$];
  adcsq_sequencer u_dut (.CLOCK(clock), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .CORE_RESULT(core_w), .MUX_SELECT(mux), .SAMPLE_HOLD(samp),
    .CONVERT_ACTIVE(conv_a), .RESOLUTION_NINE(nine_o));
  adcsq_core_model u_core (.clk(clock), .mux_select(mux), .converting(conv_a), .core_result(core_w));
  // clock and hang guard
  initial forever #5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      n_mismatch++;
      $display("ERROR timeout expected finish seen hang");
      close_out;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (e !== s)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask
  // register bus cycles
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clock);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clock);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock);
    rd_s <= 1'b0;
    @(posedge clock);
    rd_v = rdata;
  endtask
  // random select and sample code per channel
  task automatic new_cfg;
    rng = xs(rng);
    sel_a[0] = 9 + rng % 15;
    code_a[0] = rng % 8;
    rng = xs(rng);
    sel_a[1] = nine ? 24 + rng % 4 : rng % 6;
    code_a[1] = rng % 8;
  endtask
  task automatic cfg(input int ch, input int rep, input int trig);
    wr(ch ? OFS_CFG_TWO : OFS_CFG_ONE, 16'(sel_a[ch] + (code_a[ch] << CFG_SAMP_LSB) +
      (trig << CFG_TRIG_BIT) + (rep << CFG_REPEAT_BIT)));
  endtask
  // reference model: one conversion of the next expected channel
  task automatic conv;
    int ch, s, c, k, full;
    logic [RES_W-1:0] er;
    ch = exp_q.pop_front();
    full = !samp;
    k = 0;
    while (samp !== 1'b1 && k < 3000)
    begin
      @(posedge clock);
      k++;
    end
    chk("mux", 16'(sel_a[ch]), {11'h000, mux});
    s = 0;
    while (samp === 1'b1)
    begin
      s++;
      @(posedge clock);
    end
    c = 0;
    while (conv_a === 1'b1)
    begin
      c++;
      @(posedge clock);
    end
    if (full) chk("sample", 16'(((nine ? 32 : 16) << code_a[ch]) + 1), 16'(s));
    chk("convert", 16'((nine ? CONV9_CYC : CONV8_CYC) + 1), 16'(c));
    er = {5'(sel_a[ch]), nine ? 4'h5 : 4'h4};
    rd(ch ? OFS_RES_TWO : OFS_RES_ONE);
    chk("result", {7'h00, er}, {7'h00, rd_v[8:0]});
    chk("done", 16'h0001, {15'h0000, rd_v[RES_DONE_BIT]});
  endtask
  initial
  begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    rd(OFS_CONTROL);
    chk("control", 16'h0000, rd_v);
    rd(5'h1c);
    chk("unmapped", 16'h0000, rd_v);
    new_cfg;
    // no start before configuration
    wr(OFS_CONTROL, 16'h0001);
    cfg(0, 0, 1);
    repeat (40) @(posedge clock);
    chk("unconfigured", 16'h0000, {15'h0000, samp});
    wr(OFS_OTP, 16'h0000);
    exp_q.push_back(0);
    conv;
    rd(OFS_CONTROL);
    chk("control", 16'h0003, rd_v);
    // read data stands one cycle only, then returns to zero
    @(posedge clock);
    chk("rdata idle", 16'h0000, rdata);
    wr(OFS_OTP, 16'h0001);
    @(posedge clock);
    chk("lock", 16'h0000, {15'h0000, nine_o});
    // disabled queue, channel two written first
    wr(OFS_CONTROL, 16'h0000);
    cfg(1, 0, 1);
    cfg(0, 0, 1);
    rd(OFS_RES_ONE);
    chk("pending done", 16'h0000, {15'h0000, rd_v[RES_DONE_BIT]});
    chk("disabled", 16'h0000, {15'h0000, samp});
    wr(OFS_CONTROL, 16'h0001);
    exp_q = '{0, 1};
    conv;
    conv;
    // second reset, then 9-bit operation
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    nine = 1;
    new_cfg;
    wr(OFS_OTP, 16'h0001);
    @(posedge clock);
    chk("nine", 16'h0001, {15'h0000, nine_o});
    wr(OFS_CONTROL, 16'h0001);
    cfg(0, 0, 1);
    exp_q.push_back(0);
    conv;
    // repeat on one with a single slotted in, then both repeating
    cfg(0, 1, 0);
    cfg(1, 0, 1);
    exp_q = '{0, 1, 0};
    repeat (3) conv;
    cfg(1, 1, 0);
    exp_q = '{0, 1, 0, 1};
    repeat (4) conv;
    close_out;
  end
endmodule
